// ---- hw/two_wire_pkg.sv ----
package two_wire_pkg;
    // Timing
    localparam int CLK_HZ = 200_000_000;
    localparam int BIT_RATE_HZ = 100_000;
    localparam int QUARTER_CYCLES = CLK_HZ / (4 * BIT_RATE_HZ);
    localparam int BYTE_BITS = 8;

    // Register offsets
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_DATA = 2'h2;
    localparam logic [1:0] ADDR_MODE = 2'h3;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [1:0] PRESC_RST = 2'h0;
    localparam logic [3:0] PERMIT_RST = 4'hF;

    // Status codes, prescaler bits zero
    localparam logic [7:0] ST_START = 8'h08;
    localparam logic [7:0] ST_RESTART = 8'h10;
    localparam logic [7:0] ST_SLAW_ACK = 8'h18;
    localparam logic [7:0] ST_SLAW_NACK = 8'h20;
    localparam logic [7:0] ST_DATA_ACK = 8'h28;
    localparam logic [7:0] ST_DATA_NACK = 8'h30;
    localparam logic [7:0] ST_ARB_LOST = 8'h38;
    localparam logic [7:0] ST_SLAR_ACK = 8'h40;
    localparam logic [7:0] ST_SLAR_NACK = 8'h48;
    localparam logic [7:0] ST_NONE = 8'hF8;

    // Line levels
    localparam logic DIR_READ = 1'b1;
    localparam logic ACK_LEVEL = 1'b0;

    // Control register layout, msb first
    typedef struct packed {
        logic flag;
        logic ack_en;
        logic start;
        logic stop;
        logic wc;
        logic en;
        logic [1:0] spare;
    } ctrl_s;

    // Operating mode, one-hot
    typedef enum logic [3:0] {
        MODE_NONE = 4'b0000,
        MODE_MT = 4'b0001,
        MODE_MR = 4'b0010,
        MODE_ST = 4'b0100,
        MODE_SR = 4'b1000
    } mode_e;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_START = 6'b000010,
        S_SHIFT = 6'b000100,
        S_HOLD = 6'b001000,
        S_RESTART = 6'b010000,
        S_STOP = 6'b100000
    } state_e;
endpackage : two_wire_pkg

// ---- hw/two_wire_master_transmitter.sv ----
`timescale 1ns/1ps
// How it works
// - Four modes exist; software permits modes through a permit mask; the code enters only the master modes, and starts if mask bit 0 or 1 is set.
// - Read direction bit is sent high, write direction bit low.
// - Acknowledge is low on data line, not-acknowledge high.
// - Every unit after address is eight bits plus one acknowledge bit.
// - While the event flag is set the serial transfer stays suspended.
// - Status codes carry zero prescaler bits; software masks them off.
// - Address with write bit enters transmit mode, read bit enters receive mode.
// - Writing one to the flag clears it; writing zero leaves it.
// - Start is issued once the bus is free, then status 0x08 posted.
// - After write address and acknowledge slot, post 0x18, 0x20 or 0x38; a read address posts 0x40, 0x48 or 0x38.
// - Data writes while flag low are dropped and set write collision.
// - Repeated start posts 0x10 and keeps the bus owned.
// - In 0x10 a read address cleared with no requests enters receive mode; after a repeated start from receive mode the code sends stop instead.
// - In 0x18/0x20 a loaded byte is sent and acknowledge sampled.
// - In 0x18/0x20 a start request sends a repeated start.
// - In 0x18/0x20 a stop request sends stop and clears the stop bit.
// - In 0x18/0x20 both requests send stop, then start, clearing stop.
// - Status 0x38 marks arbitration lost in address or data byte.
// - In 0x38 clearing with no requests releases the bus, unaddressed.
module two_wire_master_transmitter #(
    parameter int QUARTER_CYCLES = two_wire_pkg::QUARTER_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);
    two_wire_pkg::ctrl_s ctrl_q;
    two_wire_pkg::ctrl_s wr_ctrl;
    two_wire_pkg::state_e state_q;
    two_wire_pkg::mode_e mode_q;
    logic [7:0] data_q;
    logic [1:0] presc_q;
    logic [3:0] permit_q;
    logic [4:0] code_q;
    logic [7:0] rdata_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic busy_q;
    logic [15:0] qcnt_q;
    logic tick;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [8:0] shreg_q;
    logic addr_ph_q;
    logic addr_rd_q;
    logic ack_q;
    logic master_q;
    logic post_q;
    logic stop_done_q;
    logic scl_oe_n_q, sda_oe_n_q;

    // Register decode
    wire sel_ctrl = reg_addr == two_wire_pkg::ADDR_CTRL;
    wire sel_status = reg_addr == two_wire_pkg::ADDR_STATUS;
    wire sel_data = reg_addr == two_wire_pkg::ADDR_DATA;
    wire sel_mode = reg_addr == two_wire_pkg::ADDR_MODE;
    wire wr_ctrl_en = reg_wr & sel_ctrl;
    wire wr_data_en = reg_wr & sel_data;
    wire data_ok = wr_data_en & ctrl_q.flag;
    wire data_drop = wr_data_en & ~ctrl_q.flag;
    assign wr_ctrl = two_wire_pkg::ctrl_s'(reg_wdata);

    // Read mux; status low bits show prescaler, code field on top
    wire [7:0] status_rd = {code_q, 1'b0, presc_q};
    wire [7:0] mode_rd = {mode_q, permit_q};
    wire [7:0] rd_mux = sel_ctrl ? ctrl_q :
                        sel_status ? status_rd :
                        sel_data ? data_q : mode_rd;

    // Bus condition detection on synchronised lines
    wire start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    wire stop_seen = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    wire may_master = |permit_q[1:0];
    wire go_on = ~ctrl_q.flag & ~post_q;

    assign tick = qcnt_q == 16'(QUARTER_CYCLES - 1);
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;
    assign reg_rdata = rdata_q;

    // Two-stage synchronisers plus edge history
    always_ff @(posedge clk) begin
        scl_s1_q <= scl_in;
        scl_s2_q <= scl_s1_q;
        scl_s3_q <= scl_s2_q;
        sda_s1_q <= sda_in;
        sda_s2_q <= sda_s1_q;
        sda_s3_q <= sda_s2_q;
    end

    // Bus busy between start and stop conditions
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (start_seen) begin
            busy_q <= 1'b1;
        end else if (stop_seen) begin
            busy_q <= 1'b0;
        end
    end

    // Quarter-bit enable divider
    always_ff @(posedge clk) begin
        if (sys_rst || tick) begin
            qcnt_q <= 16'h0000;
        end else begin
            qcnt_q <= qcnt_q + 16'h0001;
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    // Software-side registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= two_wire_pkg::CTRL_RST;
            data_q <= two_wire_pkg::DATA_RST;
            presc_q <= two_wire_pkg::PRESC_RST;
            permit_q <= two_wire_pkg::PERMIT_RST;
        end else begin
            if (wr_ctrl_en) begin
                ctrl_q.ack_en <= wr_ctrl.ack_en;
                ctrl_q.start <= wr_ctrl.start;
                ctrl_q.en <= wr_ctrl.en;
            end
            if (wr_ctrl_en) begin
                ctrl_q.stop <= wr_ctrl.stop;
            end else if (stop_done_q) begin
                ctrl_q.stop <= 1'b0;
            end
            if (post_q) begin
                ctrl_q.flag <= 1'b1;
            end else if (wr_ctrl_en && wr_ctrl.flag) begin
                ctrl_q.flag <= 1'b0;
            end
            if (data_drop) begin
                ctrl_q.wc <= 1'b1;
            end else if (data_ok) begin
                ctrl_q.wc <= 1'b0;
            end
            if (data_ok) begin
                data_q <= reg_wdata;
            end
            if (reg_wr && sel_status) begin
                presc_q <= reg_wdata[1:0];
            end
            if (reg_wr && sel_mode) begin
                permit_q <= reg_wdata[3:0];
            end
        end
    end

    // Serial engine; one bit is four quarter ticks
    always_ff @(posedge clk) begin
        if (sys_rst || !ctrl_q.en) begin
            state_q <= two_wire_pkg::S_IDLE;
            mode_q <= two_wire_pkg::MODE_NONE;
            code_q <= two_wire_pkg::ST_NONE[7:3];
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            shreg_q <= 9'h1FF;
            addr_ph_q <= 1'b0;
            addr_rd_q <= 1'b0;
            ack_q <= 1'b0;
            master_q <= 1'b0;
            post_q <= 1'b0;
            stop_done_q <= 1'b0;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            post_q <= 1'b0;
            stop_done_q <= 1'b0;
            if (tick) begin
                ph_q <= ph_q + 2'h1;
            end
            unique case (state_q)
                two_wire_pkg::S_IDLE: begin
                    scl_oe_n_q <= 1'b1;
                    sda_oe_n_q <= 1'b1;
                    ph_q <= 2'h0;
                    if (ctrl_q.start && !ctrl_q.flag && !busy_q && may_master) begin
                        state_q <= two_wire_pkg::S_START;
                    end
                end
                two_wire_pkg::S_START: begin
                    if (tick) begin
                        unique case (ph_q)
                            2'h1: sda_oe_n_q <= 1'b0;
                            2'h3: begin
                                scl_oe_n_q <= 1'b0;
                                master_q <= 1'b1;
                                addr_ph_q <= 1'b1;
                                code_q <= two_wire_pkg::ST_START[7:3];
                                post_q <= 1'b1;
                                state_q <= two_wire_pkg::S_HOLD;
                            end
                            default: ;
                        endcase
                    end
                end
                two_wire_pkg::S_RESTART: begin
                    if (tick) begin
                        unique case (ph_q)
                            2'h0: sda_oe_n_q <= 1'b1;
                            2'h1: scl_oe_n_q <= 1'b1;
                            2'h2: sda_oe_n_q <= 1'b0;
                            2'h3: begin
                                scl_oe_n_q <= 1'b0;
                                addr_ph_q <= 1'b1;
                                code_q <= two_wire_pkg::ST_RESTART[7:3];
                                post_q <= 1'b1;
                                state_q <= two_wire_pkg::S_HOLD;
                            end
                        endcase
                    end
                end
                two_wire_pkg::S_SHIFT: begin
                    if (tick) begin
                        unique case (ph_q)
                            2'h0: begin
                                scl_oe_n_q <= 1'b0;
                                sda_oe_n_q <= shreg_q[8];
                            end
                            2'h1: scl_oe_n_q <= 1'b1;
                            2'h2: begin
                                ack_q <= sda_s2_q == two_wire_pkg::ACK_LEVEL;
                                if (bit_q != 4'h8 && shreg_q[8] && !sda_s2_q) begin
                                    sda_oe_n_q <= 1'b1;
                                    master_q <= 1'b0;
                                    mode_q <= two_wire_pkg::MODE_NONE;
                                    code_q <= two_wire_pkg::ST_ARB_LOST[7:3];
                                    post_q <= 1'b1;
                                    state_q <= two_wire_pkg::S_HOLD;
                                end
                            end
                            2'h3: begin
                                scl_oe_n_q <= 1'b0;
                                shreg_q <= {shreg_q[7:0], 1'b1};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'(two_wire_pkg::BYTE_BITS)) begin
                                    post_q <= 1'b1;
                                    addr_ph_q <= 1'b0;
                                    state_q <= two_wire_pkg::S_HOLD;
                                    if (!addr_ph_q) begin
                                        code_q <= ack_q ? two_wire_pkg::ST_DATA_ACK[7:3]
                                                        : two_wire_pkg::ST_DATA_NACK[7:3];
                                    end else if (addr_rd_q) begin
                                        mode_q <= two_wire_pkg::MODE_MR;
                                        code_q <= ack_q ? two_wire_pkg::ST_SLAR_ACK[7:3]
                                                        : two_wire_pkg::ST_SLAR_NACK[7:3];
                                    end else begin
                                        mode_q <= two_wire_pkg::MODE_MT;
                                        code_q <= ack_q ? two_wire_pkg::ST_SLAW_ACK[7:3]
                                                        : two_wire_pkg::ST_SLAW_NACK[7:3];
                                    end
                                end
                            end
                        endcase
                    end
                end
                two_wire_pkg::S_HOLD: begin
                    ph_q <= 2'h0;
                    if (go_on) begin
                        if (!master_q) begin
                            scl_oe_n_q <= 1'b1;
                            sda_oe_n_q <= 1'b1;
                            state_q <= two_wire_pkg::S_IDLE;
                        end else if (ctrl_q.stop) begin
                            state_q <= two_wire_pkg::S_STOP;
                        end else if (ctrl_q.start) begin
                            state_q <= two_wire_pkg::S_RESTART;
                        end else if (mode_q == two_wire_pkg::MODE_MR) begin
                            state_q <= two_wire_pkg::S_STOP;
                        end else begin
                            shreg_q <= {data_q, 1'b1};
                            addr_rd_q <= data_q[0] == two_wire_pkg::DIR_READ;
                            bit_q <= 4'h0;
                            state_q <= two_wire_pkg::S_SHIFT;
                        end
                    end
                end
                two_wire_pkg::S_STOP: begin
                    if (tick) begin
                        unique case (ph_q)
                            2'h0: sda_oe_n_q <= 1'b0;
                            2'h1: scl_oe_n_q <= 1'b1;
                            2'h2: sda_oe_n_q <= 1'b1;
                            2'h3: begin
                                master_q <= 1'b0;
                                mode_q <= two_wire_pkg::MODE_NONE;
                                stop_done_q <= 1'b1;
                                state_q <= two_wire_pkg::S_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end
endmodule : two_wire_master_transmitter

// ---- dv/two_wire_props.sv ----
`timescale 1ns/1ps
module two_wire_props #(
    parameter int QUARTER_CYCLES = 6
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n
);
    localparam int SPAN = 2 * QUARTER_CYCLES + 4;
    logic scl_p_q;
    int unsigned run_q;
    // Cycles since the clock line last changed
    always_ff @(posedge clk) begin
        scl_p_q <= scl_oe_n;
        if (sys_rst || scl_oe_n != scl_p_q) begin
            run_q <= 0;
        end else if (run_q < 1000) begin
            run_q <= run_q + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Line drivers and bus timing
    chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("line output value not zero");
    chk_reset_release: assert property (disable iff (1'b0) sys_rst |=> scl_oe_n && sda_oe_n)
        else $error("lines not released after reset");
    chk_scl_spacing: assert property (scl_oe_n != scl_p_q |-> run_q >= QUARTER_CYCLES - 1)
        else $error("clock line changed inside a quarter bit");
    chk_start_clock: assert property ($fell(sda_oe_n) && scl_oe_n |-> ##[1:SPAN] $fell(scl_oe_n))
        else $error("clock not pulled low after start");
    chk_stop_idle: assert property ($rose(sda_oe_n) && scl_oe_n |=> (sda_oe_n && scl_oe_n) [*4])
        else $error("lines not idle after stop");
    chk_hold_flag: assert property (reg_rd && reg_addr == two_wire_pkg::ADDR_STATUS ##1
        (reg_rdata inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h40}) |-> !scl_oe_n)
        else $error("clock line not held while flag set");
    // Register read fields
    chk_status_low: assert property (reg_rd && reg_addr == two_wire_pkg::ADDR_STATUS
        |=> reg_rdata[2] == 1'b0)
        else $error("status bit two not zero");
    chk_ctrl_spare: assert property (reg_rd && reg_addr == two_wire_pkg::ADDR_CTRL
        |=> reg_rdata[1:0] == 2'h0)
        else $error("control spare bits not zero");
    chk_mode_onehot: assert property (reg_rd && reg_addr == two_wire_pkg::ADDR_MODE
        |=> $onehot0(reg_rdata[7:4]))
        else $error("more than one mode active");
    cover property (reg_rd ##1 reg_rdata == two_wire_pkg::ST_SLAW_ACK);
    cover property (reg_rd ##1 reg_rdata == two_wire_pkg::ST_DATA_ACK);
    cover property (reg_rd ##1 reg_rdata == two_wire_pkg::ST_ARB_LOST);
endmodule : two_wire_props

bind two_wire_master_transmitter two_wire_props #(.QUARTER_CYCLES(QUARTER_CYCLES)) i_two_wire_props (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n));

// ---- dv/two_wire_slave.sv ----
`timescale 1ns/1ps
module two_wire_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe_n,
    output logic [7:0] got_byte,
    output int n_stop
);
    logic [7:0] sh = 8'h00;
    int cnt = 0;
    logic addr_ph = 1'b0;
    logic sel = 1'b0;
    initial begin
        sda_oe_n = 1'b1;
        got_byte = 8'h00;
        n_stop = 0;
    end
    // Start and stop while the clock line is high
    always @(negedge sda) begin
        if (scl) begin
            cnt = 0;
            addr_ph = 1'b1;
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            n_stop++;
        end
    end
    // Eight bits msb first, then the acknowledge slot
    always @(posedge scl) begin
        if (cnt < 8) begin
            sh = {sh[6:0], sda};
        end
        cnt++;
    end
    // Acknowledge held low over the ninth clock only
    always @(negedge scl) begin
        if (cnt == 8) begin
            got_byte = sh;
            if (addr_ph) begin
                sel = (sh[7:1] == DEV_ADDR);
            end
            sda_oe_n = !sel;
        end else if (cnt == 9) begin
            sda_oe_n = 1'b1;
            cnt = 0;
            if (addr_ph && got_byte[0] == two_wire_pkg::DIR_READ) begin
                sel = 1'b0;
            end
            addr_ph = 1'b0;
        end
    end
endmodule : two_wire_slave

// ---- dv/tb_two_wire_master_transmitter.sv ----
`timescale 1ns/1ps
module tb_two_wire_master_transmitter;
    localparam int Q = 6;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic other_n = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, v, got_byte;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, slv_oe_n;
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & slv_oe_n & other_n;
    int n_stop, k, i;
    int num_errors = 0;
    int n_tests = 0;
    always #2.5 clk = ~clk;
    two_wire_master_transmitter #(.QUARTER_CYCLES(Q)) i_two_wire_master_transmitter (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n));
    two_wire_slave i_two_wire_slave (.scl(scl), .sda(sda), .sda_oe_n(slv_oe_n),
        .got_byte(got_byte), .n_stop(n_stop));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Optional data load, control write, wait for flag, status compare
    task automatic step(input logic ld, input logic [7:0] d, input logic [7:0] c,
        input logic [7:0] st);
        if (ld) wr(two_wire_pkg::ADDR_DATA, d);
        wr(two_wire_pkg::ADDR_CTRL, c);
        v = 8'h00;
        for (i = 0; i < 3000 && v[7] !== 1'b1; i++) rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v & 8'h80, 8'h80);
        rd(two_wire_pkg::ADDR_STATUS, v);
        chk(v & 8'hF8, st);
    endtask : step
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v, two_wire_pkg::CTRL_RST);
        rd(two_wire_pkg::ADDR_STATUS, v);
        chk(v, two_wire_pkg::ST_NONE);
        rd(two_wire_pkg::ADDR_DATA, v);
        chk(v, two_wire_pkg::DATA_RST);
        rd(two_wire_pkg::ADDR_MODE, v);
        chk(v, {4'h0, two_wire_pkg::PERMIT_RST});
        wr(two_wire_pkg::ADDR_DATA, 8'h3C);
        rd(two_wire_pkg::ADDR_DATA, v);
        chk(v, two_wire_pkg::DATA_RST);
        rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v & 8'h08, 8'h08);
        wr(two_wire_pkg::ADDR_STATUS, 8'h03);
        rd(two_wire_pkg::ADDR_STATUS, v);
        chk(v, two_wire_pkg::ST_NONE | 8'h03);
        wr(two_wire_pkg::ADDR_STATUS, 8'h00);
        wr(two_wire_pkg::ADDR_MODE, 8'h0C);
        wr(two_wire_pkg::ADDR_CTRL, 8'hA4);
        repeat (8 * Q) @(posedge clk);
        rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v & 8'h80, 8'h00);
        chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        wr(two_wire_pkg::ADDR_MODE, 8'h0F);
        $display("test reset and collision done");
        step(1'b0, 8'h00, 8'hA4, two_wire_pkg::ST_START);
        wr(two_wire_pkg::ADDR_CTRL, 8'h04);
        repeat (8 * Q) @(posedge clk);
        rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v & 8'h80, 8'h80);
        step(1'b1, 8'hA0, 8'h84, two_wire_pkg::ST_SLAW_ACK);
        chk(got_byte, 8'hA0);
        rd(two_wire_pkg::ADDR_MODE, v);
        chk(v & 8'hF0, 8'h10);
        step(1'b1, 8'h3C, 8'h84, two_wire_pkg::ST_DATA_ACK);
        chk(got_byte, 8'h3C);
        step(1'b0, 8'h00, 8'hA4, two_wire_pkg::ST_RESTART);
        step(1'b1, 8'hA1, 8'h84, two_wire_pkg::ST_SLAR_ACK);
        rd(two_wire_pkg::ADDR_MODE, v);
        chk(v & 8'hF0, 8'h20);
        $display("test write and repeated start done");
        wr(two_wire_pkg::ADDR_CTRL, 8'h84);
        step(1'b0, 8'h00, 8'hA4, two_wire_pkg::ST_START);
        step(1'b1, 8'hA4, 8'h84, two_wire_pkg::ST_SLAW_NACK);
        step(1'b0, 8'h00, 8'hB4, two_wire_pkg::ST_START);
        rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v & 8'h10, 8'h00);
        step(1'b1, 8'hA0, 8'h84, two_wire_pkg::ST_SLAW_ACK);
        k = n_stop;
        wr(two_wire_pkg::ADDR_CTRL, 8'h94);
        v = 8'h10;
        for (i = 0; i < 2000 && v[4] !== 1'b0; i++) rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v & 8'h10, 8'h00);
        chk(8'(n_stop - k), 8'h01);
        chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        $display("test stop done");
        step(1'b0, 8'h00, 8'hA4, two_wire_pkg::ST_START);
        wr(two_wire_pkg::ADDR_DATA, 8'hFE);
        wr(two_wire_pkg::ADDR_CTRL, 8'h84);
        other_n <= 1'b0;
        step(1'b0, 8'h00, 8'h04, two_wire_pkg::ST_ARB_LOST);
        other_n <= 1'b1;
        wr(two_wire_pkg::ADDR_CTRL, 8'h84);
        repeat (8 * Q) @(posedge clk);
        chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        rd(two_wire_pkg::ADDR_CTRL, v);
        chk(v & 8'h80, 8'h00);
        $display("test arbitration done");
        conclude();
    end
endmodule : tb_two_wire_master_transmitter
